//--- hw/tps_pkg.sv
// Purpose : Shared constants and types for the timer prescaler block
// Assumes : One 200 MHz peripheral clock, APB register access
// Notes   : All offsets are byte addresses on a 32-bit data bus
package tps_pkg;

	// ****************************************************************
	// Sizes
	// ****************************************************************
	localparam int unsigned NUM_SRC  = 4;
	localparam int unsigned FIELD_W  = 4;
	localparam int unsigned CNT_W    = 15;
	localparam int unsigned NUM_CH   = 16;
	localparam int unsigned SEL_W    = 2;
	localparam int unsigned ADDR_W   = 12;
	localparam int unsigned REG_W    = 16;

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam logic [11:0] PCS_OFFSET   = 12'h240;
	localparam logic [11:0] GUARD_OFFSET = 12'h244;
	localparam logic [15:0] PCS_RESET    = 16'hffff;
	localparam logic [3:0]  GUARD_RESET  = 4'h0;
	localparam logic [14:0] CNT_RESET    = 15'h0000;

	// Field i occupies bits [i*FIELD_POS +: FIELD_W]
	localparam int unsigned FIELD_POS = 4;
	localparam int unsigned FIRST_LSB  = 0;
	localparam int unsigned SECOND_LSB = 4;
	localparam int unsigned THIRD_LSB  = 8;
	localparam int unsigned FOURTH_LSB = 12;

	// ****************************************************************
	// Types and helpers
	// ****************************************************************
	typedef enum logic [1:0]
	{
		ST_IDLE   = 2'b01,
		ST_ACCESS = 2'b10
	} tps_apb_st_t;

	// Low bits that must all be ones for a divide-by-2^f pulse
	function automatic logic [14:0] tps_mask(input logic [3:0] f);
		tps_mask = (15'h0001 << f) - 15'h0001;
	endfunction : tps_mask

endpackage : tps_pkg

//--- hw/tps_div_if.sv
// Purpose : Carries counter and divider fields to the divider, enables back
// Assumes : Both ends sit on the same clock
// Notes   : Purely combinational signals
`timescale 1ns/1ps
`default_nettype none
interface tps_div_if;
	import tps_pkg::*;
	logic [CNT_W-1:0]   cnt;
	logic [REG_W-1:0]   fields;
	logic [NUM_SRC-1:0] en;

	modport ctl (output cnt, output fields, input en);
	modport div (input cnt, input fields, output en);
endinterface : tps_div_if
`default_nettype wire

//--- hw/tps_divider.sv
// Purpose : Turns the free-running count into four divided enables
// Assumes : Counter increments by one every peripheral clock
// Notes   : Output is combinational; the top registers it
`timescale 1ns/1ps
`default_nettype none
module tps_divider
	import tps_pkg::*;
(
	tps_div_if.div bus
);

	// ****************************************************************
	// One decoder per source
	// ****************************************************************
	genvar i;
	generate
		for (i = 0; i < NUM_SRC; i++)
		begin : g_src
			logic [FIELD_W-1:0] f;
			assign f = bus.fields[i*FIELD_POS +: FIELD_W];
			// Field zero passes every clock; otherwise low bits all ones
			assign bus.en[i] = (f == 4'h0) ||
				((bus.cnt & tps_mask(f)) == tps_mask(f));
		end
	endgenerate

endmodule : tps_divider
`default_nettype wire

//--- hw/tps_top.sv
// Purpose : Shared prescaler: four count-clock enables, per-channel pick
// Assumes : APB master on clk_sys_i; channel inputs on the same clock
// Notes   : Divided clocks are one-cycle enables, never real clocks
//
// Behaviour
// - One 16-bit read/write register, four divider fields
// - Bits 15:12 divide fourth clock by 2^field
// - Bits 11:8 divide third clock by 2^field
// - Bits 7:4 divide second clock by 2^field
// - Bits 3:0 divide first clock by 2^field
// - Each channel picks one clock by 2-bit code
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module tps_top
	import tps_pkg::*;
(
	input  wire logic                    clk_sys_i,
	input  wire logic                    rst_i,
	input  wire logic                    psel_i,
	input  wire logic                    penable_i,
	input  wire logic                    pwrite_i,
	input  wire logic [ADDR_W-1:0]       paddr_i,
	input  wire logic [31:0]             pwdata_i,
	output logic      [31:0]             prdata_o,
	output logic                         pready_o,
	output logic                         pslverr_o,
	input  wire logic [NUM_CH-1:0]       channel_enable_status_i,
	input  wire logic [NUM_CH*SEL_W-1:0] operation_clock_select_i,
	output logic      [NUM_SRC-1:0]      count_clock_en_o,
	output logic      [NUM_CH-1:0]       channel_clock_en_o
);

	// ****************************************************************
	// State
	// ****************************************************************
	tps_apb_st_t        st_reg,     st_next;
	logic [31:0]        rdata_reg,  rdata_next;
	logic               ready_reg,  ready_next;
	logic               err_reg,    err_next;
	logic [REG_W-1:0]   pcs_reg,    pcs_next;
	logic [NUM_SRC-1:0] guard_reg,  guard_next;
	logic [CNT_W-1:0]   cnt_reg,    cnt_next;
	logic [NUM_SRC-1:0] src_en_reg;
	logic [NUM_CH-1:0]  ch_en_reg,  ch_en_next;

	logic               setup;
	logic               wr_acc;
	logic               rd_acc;
	logic               hit_pcs;
	logic               hit_guard;
	logic [NUM_SRC-1:0] src_busy;
	logic [NUM_SRC-1:0] field_chg;

	tps_div_if div_bus ();

	// ****************************************************************
	// Divider
	// ****************************************************************
	assign div_bus.cnt    = cnt_reg;
	assign div_bus.fields = pcs_reg;

	tps_divider u_div
	(
		.bus (div_bus.div)
	);

	// ****************************************************************
	// APB decode
	// ****************************************************************
	// Setup cycle is where the decode is latched for the access phase
	assign setup     = psel_i && !penable_i;
	assign hit_pcs   = (paddr_i == PCS_OFFSET);
	assign hit_guard = (paddr_i == GUARD_OFFSET);
	// Write lands only at the edge where the master sees pready
	assign wr_acc    = psel_i && penable_i && ready_reg && pwrite_i;
	assign rd_acc    = psel_i && penable_i && ready_reg && !pwrite_i;

	// APB handshake: one wait-free access cycle after setup
	always_comb
	begin
		st_next    = st_reg;
		rdata_next = rdata_reg;
		ready_next = 1'b0;
		err_next   = 1'b0;
		case (st_reg)
			ST_IDLE:
			begin
				if (setup)
				begin
					st_next    = ST_ACCESS;
					ready_next = 1'b1;
					err_next   = !(hit_pcs || hit_guard);
					if (hit_pcs)
						rdata_next = {16'h0000, pcs_reg};
					else if (hit_guard)
						rdata_next = {28'h0000000, guard_reg};
					else
						rdata_next = 32'h0000_0000;
				end
			end
			ST_ACCESS:
			begin
				st_next = ST_IDLE;
			end
			default:
			begin
				st_next = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			st_reg    <= ST_IDLE;
			rdata_reg <= 32'h0000_0000;
			ready_reg <= 1'b0;
			err_reg   <= 1'b0;
		end
		else
		begin
			st_reg    <= st_next;
			rdata_reg <= rdata_next;
			ready_reg <= ready_next;
			err_reg   <= err_next;
		end
	end

	// ****************************************************************
	// Prescaler setting and guard flags
	// ****************************************************************
	// A source is busy while any running channel has it selected
	always_comb
	begin
		src_busy = '0;
		for (int m = 0; m < NUM_CH; m++)
		begin
			if (channel_enable_status_i[m])
				src_busy[operation_clock_select_i[m*SEL_W +: SEL_W]] = 1'b1;
		end
	end

	// Guard bit per source: set when a running source is retuned.
	// The divider still obeys the write; the flag only reports misuse.
	always_comb
	begin
		pcs_next   = pcs_reg;
		guard_next = guard_reg;
		field_chg  = '0;
		for (int i = 0; i < NUM_SRC; i++)
		begin
			field_chg[i] = wr_acc && hit_pcs &&
				(pwdata_i[i*FIELD_POS +: FIELD_W] !=
				 pcs_reg[i*FIELD_POS +: FIELD_W]);
		end
		if (wr_acc && hit_pcs)
			pcs_next = pwdata_i[REG_W-1:0];
		// Write one to clear; a new event in the same cycle wins
		if (wr_acc && hit_guard)
			guard_next = guard_reg & ~pwdata_i[NUM_SRC-1:0];
		guard_next = guard_next | (field_chg & src_busy);
	end

	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			pcs_reg   <= PCS_RESET;
			guard_reg <= GUARD_RESET;
		end
		else
		begin
			pcs_reg   <= pcs_next;
			guard_reg <= guard_next;
		end
	end

	// ****************************************************************
	// Free-running counter and enables
	// ****************************************************************
	// Counter never stops, so retuning a field shifts phase only once
	always_comb
	begin
		cnt_next = cnt_reg + 15'h0001;
		for (int m = 0; m < NUM_CH; m++)
		begin
			ch_en_next[m] =
				div_bus.en[operation_clock_select_i[m*SEL_W +: SEL_W]];
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			cnt_reg    <= CNT_RESET;
			src_en_reg <= '0;
			ch_en_reg  <= '0;
		end
		else
		begin
			cnt_reg    <= cnt_next;
			src_en_reg <= div_bus.en;
			ch_en_reg  <= ch_en_next;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign prdata_o           = rdata_reg;
	assign pready_o           = ready_reg;
	assign pslverr_o          = err_reg;
	assign count_clock_en_o   = src_en_reg;
	assign channel_clock_en_o = ch_en_reg;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);

	sequence s_setup;
		psel_i && !penable_i && (st_reg == ST_IDLE);
	endsequence

	sequence s_answer;
		pready_o ##1 !pready_o;
	endsequence

	a_apb_one_wait: assert property (s_setup |=> s_answer)
		else $error("pready not a single cycle after setup");

	a_reg_write: assert property (
		(wr_acc && hit_pcs) |=> (pcs_reg == $past(pwdata_i[15:0])))
		else $error("setting register did not take write data");

	a_reg_read: assert property (
		(s_setup and hit_pcs) |=> (prdata_o == {16'h0000, pcs_reg}))
		else $error("read data differs from setting register");

	a_fourth_rate: assert property (
		count_clock_en_o[3] == (($past(pcs_reg[15:12]) == 4'h0) ||
		(($past(cnt_reg) & tps_mask($past(pcs_reg[15:12]))) ==
		 tps_mask($past(pcs_reg[15:12])))))
		else $error("fourth enable off its divide ratio");

	a_third_rate: assert property (
		count_clock_en_o[2] == (($past(pcs_reg[11:8]) == 4'h0) ||
		(($past(cnt_reg) & tps_mask($past(pcs_reg[11:8]))) ==
		 tps_mask($past(pcs_reg[11:8])))))
		else $error("third enable off its divide ratio");

	a_second_rate: assert property (
		count_clock_en_o[1] == (($past(pcs_reg[7:4]) == 4'h0) ||
		(($past(cnt_reg) & tps_mask($past(pcs_reg[7:4]))) ==
		 tps_mask($past(pcs_reg[7:4])))))
		else $error("second enable off its divide ratio");

	a_first_rate: assert property (
		count_clock_en_o[0] == (($past(pcs_reg[3:0]) == 4'h0) ||
		(($past(cnt_reg) & tps_mask($past(pcs_reg[3:0]))) ==
		 tps_mask($past(pcs_reg[3:0])))))
		else $error("first enable off its divide ratio");

	a_pulse_single: assert property (
		(count_clock_en_o[0] && (pcs_reg[3:0] != 4'h0) &&
		 $stable(pcs_reg[3:0])) |=> !count_clock_en_o[0])
		else $error("divided enable wider than one cycle");

	a_guard_set: assert property (
		(field_chg[0] && src_busy[0]) |=> guard_reg[0])
		else $error("running source retune not flagged");

	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++)
		begin : g_chk
			a_chan_select: assert property (
				channel_clock_en_o[g] == count_clock_en_o[
					$past(operation_clock_select_i[g*SEL_W +: SEL_W])])
				else $error("channel enable not from selected source");
		end
	endgenerate

endmodule : tps_top
`default_nettype wire

//--- verification/tps_chan_model.sv
// Purpose : Timer channel stand-in: run status and clock picks
// Assumes : Same clock as the prescaler
// Notes   : Picks change only while every channel is stopped
`timescale 1ns/1ps
`default_nettype none
module tps_chan_model
	import tps_pkg::*;
(
	input  wire logic                    clk_sys_i,
	input  wire logic                    rst_i,
	input  wire logic                    run_i,
	input  wire logic                    load_i,
	input  wire logic [NUM_CH*SEL_W-1:0] new_sel_i,
	output logic      [NUM_CH-1:0]       status_o,
	output logic      [NUM_CH*SEL_W-1:0] sel_o
);
	// ****************
	// Channel state
	// ****************
	// A new pick is refused while any counter runs, like the real mode reg
	always @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			status_o <= '0;
			sel_o    <= '0;
		end
		else
		begin
			status_o <= {NUM_CH{run_i}};
			if (load_i && status_o == '0)
			begin
				sel_o <= new_sel_i;
			end
		end
	end
endmodule : tps_chan_model
`default_nettype wire

//--- verification/tps_top_tb.sv
// Purpose : Self-checking bench for the timer prescaler
// Assumes : APB master, 200 MHz clock, channels stopped on field writes except the final retune
// Notes   : A cycle model predicts every enable; reads are checked against expected values
`timescale 1ns/1ps
`default_nettype none
module tps_top_tb;
	import tps_pkg::*;
	logic        clk_sys_i = 1'b0;
	logic        rst_i;
	logic        psel, penable, pwrite, pready, pslverr, err, run, load;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, new_sel, sel, v;
	logic [15:0] status, ch_en, x_ch, mf;
	logic [3:0]  cc_en, x_en, g;
	int          errors = 0, comparisons = 0, seed = 32'h50ac, mcnt;

	tps_top tps_top_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
		.psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
		.paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr),
		.channel_enable_status_i(status), .operation_clock_select_i(sel),
		.count_clock_en_o(cc_en), .channel_clock_en_o(ch_en));
	tps_chan_model tps_chan_model_inst (.clk_sys_i(clk_sys_i),
		.rst_i(rst_i), .run_i(run), .load_i(load), .new_sel_i(new_sel),
		.status_o(status), .sel_o(sel));

	// 200 MHz clock
	always #2.5 clk_sys_i = ~clk_sys_i;

	// ****************
	// Reference model
	// ****************
	// Predict from old fields first: a write lands after this edge
	always @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			mcnt = 0;
			mf   = PCS_RESET;
			x_en = '0;
			x_ch = '0;
		end
		else
		begin
			for (int i = 0; i < 4; i++)
				x_en[i] = (mcnt % (1 << mf[4*i+:4])) == (1 << mf[4*i+:4]) - 1;
			for (int m = 0; m < 16; m++)
				x_ch[m] = x_en[sel[2*m+:2]];
			mcnt = (mcnt + 1) % 32768;
			if (psel && penable && pready && pwrite && paddr == PCS_OFFSET)
				mf = pwdata[15:0];
		end
	end

	// Enables are compared every cycle, away from the edge
	always @(negedge clk_sys_i)
		if (!rst_i)
			chk_clk({ch_en, cc_en}, {x_ch, x_en});

	// ****************
	// Tasks
	// ****************
	task automatic chk_clk(input logic [19:0] got, input logic [19:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			errors++;
			$display("BAD %0t enables %h want %h", $time, got, exp);
		end
	endtask : chk_clk

	task automatic chk_bus(input logic [32:0] got, input logic [32:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			errors++;
			$display("BAD %0t bus %h want %h", $time, got, exp);
		end
	endtask : chk_bus

	// One APB transfer; waits for pready, bounded, then releases
	task automatic rw(input logic w, input logic [11:0] a,
		input logic [31:0] d, input logic [32:0] x);
		int n = 0;
		@(posedge clk_sys_i);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge clk_sys_i);
		penable <= 1'b1;
		do
		begin
			@(posedge clk_sys_i);
			n++;
		end while (pready !== 1'b1 && n < 8);
		if (pready !== 1'b1)
		begin
			errors++;
			close_out();
		end
		rd  = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		chk_bus({err, w ? 32'h0 : rd}, x);
	endtask : rw

	task automatic close_out;
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : close_out

	// ****************
	// Main sequence
	// ****************
	// Long first run lets the divide-by-2^15 reset setting fire once
	initial
	begin
		rst_i = 1'b1;
		{psel, penable, pwrite, run, load} = '0;
		paddr   = '0;
		pwdata  = '0;
		new_sel = '0;
		repeat (3) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		rw(1'b0, PCS_OFFSET, 32'h0, {1'b0, 32'hffff});
		rw(1'b0, GUARD_OFFSET, 32'h0, 33'h0);
		new_sel <= $random(seed);
		load    <= 1'b1;
		@(posedge clk_sys_i);
		load <= 1'b0;
		run  <= 1'b1;
		repeat (33000) @(posedge clk_sys_i);
		for (int k = 0; k < 24; k++)
		begin
			run <= 1'b0;
			repeat (2) @(posedge clk_sys_i);
			new_sel <= $random(seed);
			load    <= 1'b1;
			@(posedge clk_sys_i);
			load <= 1'b0;
			v = {16'h0, k[3:0], ~k[3:0], k[3:0], ~k[3:0]};
			if (k > 15)
				v = $random(seed);
			rw(1'b1, PCS_OFFSET, v, 33'h0);
			rw(1'b0, PCS_OFFSET, 32'h0, {17'h0, v[15:0]});
			run <= 1'b1;
			repeat (300) @(posedge clk_sys_i);
		end
		// Retune every field while all channels run: each source that
		// some channel picks must be flagged, then cleared by a 1 write
		g = '0;
		for (int m = 0; m < 16; m++)
			g[sel[2*m+:2]] = 1'b1;
		v = ~v;
		rw(1'b1, PCS_OFFSET, v, 33'h0);
		rw(1'b0, GUARD_OFFSET, 32'h0, {29'h0, g});
		rw(1'b1, GUARD_OFFSET, 32'hf, 33'h0);
		rw(1'b0, GUARD_OFFSET, 32'h0, 33'h0);
		rw(1'b1, 12'h248, 32'hffffffff, {1'b1, 32'h0});
		rw(1'b0, 12'h248, 32'h0, {1'b1, 32'h0});
		rw(1'b0, PCS_OFFSET, 32'h0, {17'h0, v[15:0]});
		rst_i <= 1'b1;
		repeat (3) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		rw(1'b0, PCS_OFFSET, 32'h0, {1'b0, 32'hffff});
		close_out();
	end
endmodule : tps_top_tb
`default_nettype wire
